// ### rtl/sdrc_ctrl.sv
// SDRAM access and refresh controller with APB registers.
// Assumes a memory requester that holds its request until memAck.
`timescale 1ns/100ps
module sdrc_ctrl #(
  parameter int PD_STOP = sdrc_pkg::PD_STOP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [sdrc_pkg::PADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepMode,
  input wire logic memReq,
  input wire logic memWrite,
  input wire logic [1:0] memBank,
  input wire logic [sdrc_pkg::ROW_W-1:0] memRow,
  input wire logic [sdrc_pkg::COL_W-1:0] memCol,
  output logic memAck,
  output logic sdCke,
  output logic sdCsN,
  output logic sdRasN,
  output logic sdCasN,
  output logic sdWeN,
  output logic [1:0] sdBa,
  output logic [sdrc_pkg::ADDR_W-1:0] sdAddr,
  output logic [1:0] memClkOutEn
);
  import sdrc_pkg::*;

  if (PD_STOP < 2 || PD_STOP > 14)
    $error("PD_STOP must lie between 2 and 14");

  typedef struct packed {
    sdrc_state_type st;
    logic [3:0] openV;
    logic [3:0][ROW_W-1:0] openRow;
    logic [LOCK_W-1:0] lock;
    logic [LOCK_W-1:0] cnt;
    logic refPend;
    logic modePend;
    logic [MODE_X_W-1:0] modeAddr;
    logic [31:0] ctrl;
    logic [SEL_W-1:0] clkSel;
    logic matchFlag;
    logic [CNT_W-1:0] constR;
    logic cntWr;
    logic [CNT_W-1:0] cntWrData;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
    logic [1:0] clkOn;
    logic pair;
    logic memAck;
  } sdrc_ctl_state_type;

  sdrc_ctl_state_type r;
  sdrc_ctl_state_type n;
  sdrc_tmr_if tmrIf ();

  logic access, isMode, byteOk, wrNow, lock0, idleGo;
  logic refEn, refMode, selfWant, refWant, hit;
  logic goSelf, goRef, goMode, goAcc, goHit, goMiss, isRwCmd;
  logic [FLD_W-1:0] trc, tras;
  logic [1:0] b;

  // ----------------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------------
  sdrc_refresh_timer i_sdrc_refresh_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .tmr(tmrIf.tmr)
  );

  assign tmrIf.clkSel = r.clkSel;
  assign tmrIf.cntWr = r.cntWr;
  assign tmrIf.cntWrData = r.cntWrData;
  assign tmrIf.constVal = r.constR;

  // ----------------------------------------------------------------------
  // Decisions
  // ----------------------------------------------------------------------
  // Bus decode and control fields
  assign access = psel && penable;
  assign isMode = paddr[PADDR_W-1 -: 4] == MODE_REGION;
  assign byteOk = $onehot(pstrb);
  assign wrNow = access && r.pready && pwrite && !r.pslverr;
  assign refEn = r.ctrl[CTL_REF_EN];
  assign refMode = r.ctrl[CTL_REF_MODE];
  assign trc = r.ctrl[CTL_TRC_LSB +: FLD_W];
  assign tras = r.ctrl[CTL_TRAS_LSB +: FLD_W];
  assign b = memBank;

  // Priority: self-refresh, auto-refresh, mode set, then bus access
  assign selfWant = refEn && (refMode || sleepMode);
  assign refWant = r.refPend && refEn && !refMode;
  assign lock0 = r.lock == '0;
  assign idleGo = r.st == ST_IDLE && lock0;
  assign hit = r.openV[b] && (r.openRow[b] == memRow);
  assign goSelf = idleGo && selfWant;
  assign goRef = idleGo && !selfWant && refWant;
  assign goMode = idleGo && !selfWant && !refWant && r.modePend;
  assign goAcc = idleGo && !selfWant && !refWant && !r.modePend && memReq;
  assign goHit = goAcc && hit;
  assign goMiss = goAcc && !hit && r.openV[b];
  assign isRwCmd = r.cmd == CMD_READ || r.cmd == CMD_WRITE;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = r;
    n.cmd = CMD_NOP;
    n.memAck = 1'b0;
    n.cntWr = 1'b0;
    n.pready = 1'b0;
    if (!lock0)
      n.lock = r.lock - LOCK_W'(1);

    // APB answer one cycle into the access phase; region waits if busy
    if (access && !r.pready && !(isMode && r.modePend))
    begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (isMode)
        n.pslverr = !(pwrite && byteOk);
      else
        case (paddr)
          ADDR_CTRL: n.prdata = r.ctrl;
          ADDR_TCSR:
          begin
            n.prdata[TCS_MATCH] = r.matchFlag;
            n.prdata[SEL_W-1:0] = r.clkSel;
          end
          ADDR_CNT: n.prdata[CNT_W-1:0] = tmrIf.cntVal;
          ADDR_CONST: n.prdata[CNT_W-1:0] = r.constR;
          ADDR_STAT:
          begin
            n.prdata[6:0] = r.st;
            n.prdata[STAT_REFP] = r.refPend;
            n.prdata[STAT_MODEP] = r.modePend;
            n.prdata[STAT_CKE] = r.cke;
          end
          default: n.pslverr = 1'b1;
        endcase
    end

    // Writes land at the edge where the master sees pready
    if (wrNow)
    begin
      if (isMode)
      begin
        n.modeAddr = paddr[MODE_X_W-1:0];
        n.modePend = 1'b1;
      end
      else
        case (paddr)
          ADDR_CTRL: n.ctrl = pwdata & CTRL_MASK;
          ADDR_TCSR:
          begin
            n.clkSel = pwdata[SEL_W-1:0];
            if (pwdata[TCS_MATCH])
              n.matchFlag = 1'b0;
          end
          ADDR_CNT:
          begin
            n.cntWr = 1'b1;
            n.cntWrData = pwdata[CNT_W-1:0];
          end
          ADDR_CONST: n.constR = pwdata[CNT_W-1:0];
          default: ;
        endcase
    end

    // A match sets over any clear; one pending request at most
    if (tmrIf.match)
    begin
      n.matchFlag = 1'b1;
      n.refPend = 1'b1;
    end

    unique case (r.st)
      ST_IDLE:
      begin
        n.cke = 1'b1;
        if (goSelf || goRef)
        begin
          n.cmd = CMD_PRE;
          n.addr = ADDR_W'(1) << A10_BIT;
          n.openV = '0;
          n.lock = T_PC_CYC;
          n.st = goSelf ? ST_SELFIN : ST_REF;
        end
        else if (goMode)
        begin
          n.modePend = 1'b0;
          n.lock = T_PC_CYC;
          if (r.ctrl[CTL_MSEL])
          begin
            n.cmd = CMD_MRS;
            n.addr = ADDR_W'(r.modeAddr);
          end
          else
          begin
            n.cmd = CMD_PRE;
            n.addr = ADDR_W'(1) << A10_BIT;
            n.openV = '0;
          end
        end
        else if (goHit)
          n.st = ST_RW;
        else if (goMiss)
        begin
          n.cmd = CMD_PRE;
          n.ba = b;
          n.addr = '0;
          n.openV[b] = 1'b0;
          n.lock = T_PC_CYC;
          n.st = ST_ACT;
        end
        else if (goAcc)
          n.st = ST_ACT;
        else if (lock0)
        begin
          n.cke = 1'b0;
          n.cnt = '0;
          n.st = ST_PDOWN;
        end
      end
      ST_ACT:
        if (lock0)
        begin
          n.cmd = CMD_ACT;
          n.ba = b;
          n.addr = memRow;
          n.openV[b] = 1'b1;
          n.openRow[b] = memRow;
          n.lock = T_RCD_CYC;
          n.st = ST_RW;
        end
      ST_RW:
        if (lock0)
        begin
          n.cmd = memWrite ? CMD_WRITE : CMD_READ;
          n.ba = b;
          n.addr = ADDR_W'(memCol);
          n.memAck = 1'b1;
          n.pair = b[1];
          n.lock = T_ACK_GAP;
          n.st = ST_IDLE;
        end
      ST_REF:
        if (lock0)
        begin
          n.cmd = CMD_REF;
          n.cke = 1'b1;
          n.refPend = tmrIf.match;
          n.lock = LOCK_W'(trc);
          n.st = ST_IDLE;
        end
      ST_SELFIN:
        if (lock0)
        begin
          n.cmd = CMD_REF;
          n.cke = 1'b0;
          n.cnt = '0;
          n.refPend = tmrIf.match;
          n.st = ST_SELF;
        end
      ST_SELF:
      begin
        n.cke = 1'b0;
        if (r.cnt != '1)
          n.cnt = r.cnt + LOCK_W'(1);
        if (!selfWant && r.cnt >= LOCK_W'(tras))
        begin
          n.cke = 1'b1;
          n.lock = LOCK_W'(trc);
          n.st = ST_IDLE;
        end
      end
      ST_PDOWN:
      begin
        n.cke = 1'b0;
        if (r.cnt != '1)
          n.cnt = r.cnt + LOCK_W'(1);
        if (memReq || refWant || selfWant || r.modePend)
        begin
          n.cke = 1'b1;
          n.clkOn = 2'b11;
          n.st = ST_IDLE;
        end
        else if (r.cnt >= LOCK_W'(PD_STOP))
          n.clkOn[~r.pair] = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.cmd <= CMD_NOP;
      r.cke <= 1'b1;
      r.clkOn <= 2'b11;
    end
    else
      r <= n;
  end

  // Pins straight from flip-flops
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign memAck = r.memAck;
  assign sdCke = r.cke;
  assign {sdCsN, sdRasN, sdCasN, sdWeN} = r.cmd;
  assign sdBa = r.ba;
  assign sdAddr = r.addr;
  assign memClkOutEn = r.clkOn;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_rw_open_bank: assert property (
    isRwCmd |-> r.openV[r.ba]) else $error("read or write to closed bank");
  chk_closed_activate: assert property (
    (goAcc && !r.openV[b]) |=> r.st == ST_ACT ##1 r.cmd == CMD_ACT)
    else $error("closed bank not activated");
  chk_hit_direct: assert property (
    goHit |=> r.cmd == CMD_NOP ##1 isRwCmd) else $error("row hit not direct");
  chk_miss_order: assert property (
    goMiss |=> r.cmd == CMD_PRE && !r.addr[A10_BIT] ##3 r.cmd == CMD_ACT)
    else $error("row miss order wrong");
  chk_clock_stop_late: assert property (
    (r.clkOn != 2'b11) |-> !r.cke && !$past(r.cke) && !$past(r.cke, 2) && !$past(r.cke, 3))
    else $error("clock stopped too early");
  chk_wake_clock: assert property (
    (r.st == ST_PDOWN && memReq) |=> r.cke && r.clkOn == 2'b11)
    else $error("no wake on access");
  chk_pair_kept: assert property (
    (r.clkOn != 2'b11) |-> r.clkOn[r.pair]) else $error("accessed pair clock stopped");
  chk_self_entry: assert property (
    goSelf |=> r.cmd == CMD_PRE && r.addr[A10_BIT] ##3 r.cmd == CMD_REF && !r.cke)
    else $error("self-refresh entry sequence wrong");
  chk_self_quiet: assert property (
    (r.st == ST_SELF && $past(r.st) == ST_SELF) |-> !r.cke && r.cmd == CMD_NOP && !r.memAck)
    else $error("activity during self-refresh");
  chk_self_exit_min: assert property (
    ($past(r.st) == ST_SELF && r.st == ST_IDLE) |-> $past(r.cnt) >= LOCK_W'(tras))
    else $error("clock enable low time too short");
  chk_cke_commands: assert property (
    (r.cmd != CMD_NOP && r.st != ST_SELF) |-> r.cke) else $error("command with cke low");
  chk_mode_command: assert property (
    (goMode && r.ctrl[CTL_MSEL]) |=> r.cmd == CMD_MRS && r.addr == ADDR_W'($past(r.modeAddr)))
    else $error("mode set command wrong");

  cov_row_hit: cover property (goHit);
  cov_row_miss: cover property (goMiss);
  cov_auto_ref: cover property (r.cmd == CMD_REF && r.cke);
  cov_self_exit: cover property (r.st == ST_SELF ##1 r.st == ST_IDLE);
endmodule

// ### rtl/sdrc_refresh_timer.sv
// Refresh timer: prescaler, up counter and constant compare.
// Assumes settings come from flip-flops in the controller.
`timescale 1ns/100ps
module sdrc_refresh_timer (
  input wire logic clk_sys,
  input wire logic rst,
  sdrc_tmr_if.tmr tmr
);
  import sdrc_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [CNT_W-1:0] cnt;
    logic match;
  } sdrc_tmr_state_type;

  sdrc_tmr_state_type r;
  sdrc_tmr_state_type n;
  logic [DIV_W-1:0] mask;

  // Divide by four to the power of the select code, code 0 stops the counter; runs in sleep too
  always_comb
  begin
    n = r;
    n.match = 1'b0;
    n.div = r.div + DIV_W'(1);
    mask = (DIV_W'(1) << {tmr.clkSel, 1'b0}) - DIV_W'(1);
    if (tmr.cntWr)
      n.cnt = tmr.cntWrData;
    else if (tmr.clkSel != '0)
    begin
      if (r.cnt == tmr.constVal)
      begin
        n.match = 1'b1;
        n.cnt = '0;
      end
      else if ((r.div & mask) == mask)
        n.cnt = r.cnt + CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign tmr.cntVal = r.cnt;
  assign tmr.match = r.match;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  chk_match_equal: assert property (@(posedge clk_sys) disable iff (rst)
    r.match |-> r.cnt == '0 || $past(tmr.cntWr))
    else $error("match without counter clear");
  chk_counter_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (tmr.clkSel == '0 && !tmr.cntWr) |=> $stable(r.cnt))
    else $error("counter moved with no clock selected");
endmodule

// ### shared/sdrc_pkg.sv
// Shared constants and types for the SDRAM access and refresh controller.
// Assumes a single 125 MHz system clock and an APB register port.
package sdrc_pkg;
  // --------------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int ADDR_W = 13;
  localparam int LOCK_W = 4;
  localparam int DIV_W = 14;
  localparam int SEL_W = 3;
  localparam int FLD_W = 3;
  localparam int MODE_X_W = 12;
  localparam int PADDR_W = 16;

  // --------------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------------
  localparam logic [15:0] ADDR_CTRL = 16'h0000;
  localparam logic [15:0] ADDR_TCSR = 16'h0004;
  localparam logic [15:0] ADDR_CNT = 16'h0008;
  localparam logic [15:0] ADDR_CONST = 16'h000c;
  localparam logic [15:0] ADDR_STAT = 16'h0010;
  localparam logic [3:0] MODE_REGION = 4'ha;
  localparam int CTL_REF_EN = 0;
  localparam int CTL_REF_MODE = 1;
  localparam int CTL_MSEL = 2;
  localparam int CTL_TRC_LSB = 4;
  localparam int CTL_TRAS_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0777;
  localparam int TCS_MATCH = 7;
  localparam int STAT_REFP = 8;
  localparam int STAT_MODEP = 9;
  localparam int STAT_CKE = 10;

  // --------------------------------------------------------------------
  // Timing in cycles
  // --------------------------------------------------------------------
  localparam logic [LOCK_W-1:0] T_RCD_CYC = 4'h1;
  localparam logic [LOCK_W-1:0] T_PC_CYC = 4'h2;
  localparam logic [LOCK_W-1:0] T_ACK_GAP = 4'h1;
  localparam int PD_STOP_CYC = 2;

  // --------------------------------------------------------------------
  // Commands as {cs_n, ras_n, cas_n, we_n}, and states
  // --------------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam int A10_BIT = 10;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ACT = 7'h02,
    ST_RW = 7'h04,
    ST_REF = 7'h08,
    ST_SELFIN = 7'h10,
    ST_SELF = 7'h20,
    ST_PDOWN = 7'h40
  } sdrc_state_type;
endpackage

// ### shared/sdrc_tmr_if.sv
// Link between the controller and its refresh timer.
// Assumes both ends run on clk_sys.
`timescale 1ns/100ps
interface sdrc_tmr_if;
  import sdrc_pkg::*;
  logic [SEL_W-1:0] clkSel;
  logic cntWr;
  logic [CNT_W-1:0] cntWrData;
  logic [CNT_W-1:0] constVal;
  logic [CNT_W-1:0] cntVal;
  logic match;
  modport ctl (output clkSel, cntWr, cntWrData, constVal, input cntVal, match);
  modport tmr (input clkSel, cntWr, cntWrData, constVal, output cntVal, match);
endinterface

// ### verif/sdram_access_refresh_ctrl_test.sv
// Self-checking bench for the SDRAM access and refresh controller.
// Assumes the controller, its package and the SDRAM partner model.
`timescale 1ns/100ps
module sdram_access_refresh_ctrl_test;
  import sdrc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic sleepMode = 1'b0;
  logic memReq = 1'b0;
  logic memWrite = 1'b0;
  logic [1:0] memBank = '0;
  logic [ROW_W-1:0] memRow = '0;
  logic [COL_W-1:0] memCol = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, memAck, sdCke, sdCsN, sdRasN, sdCasN, sdWeN, preAll, er;
  logic [1:0] sdBa, memClkOutEn;
  logic [ADDR_W-1:0] sdAddr, mrsAddr;
  logic [3:0] cmd;
  int fails = 0, num_checks = 0, cyc = 0, protoErrs;
  int actCnt = 0, preCnt = 0, refCnt = 0, slfCnt = 0, mrsCnt = 0, ackCnt = 0;
  int sinceRef = 99, minGap = 99;
  localparam int PWRUP_WAIT = 25000; // 200 us of 8 ns cycles before the first mode command
  sdrc_ctrl i_sdrc_ctrl (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sleepMode, .memReq, .memWrite, .memBank, .memRow, .memCol,
    .memAck, .sdCke, .sdCsN, .sdRasN, .sdCasN, .sdWeN, .sdBa, .sdAddr, .memClkOutEn);
  sdrc_sdram_model i_sdrc_sdram_model (.clk_sys, .sdCke, .cmd, .sdBa, .sdAddr, .protoErrs);
  assign cmd = {sdCsN, sdRasN, sdCasN, sdWeN};
  always #4 clk_sys = ~clk_sys;
  // Command counters, lockout gap and watchdog
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fails++;
      tally_and_finish();
    end
    if (!rst)
    begin
      sinceRef <= (cmd === CMD_REF) ? 0 : sinceRef + 1;
      ackCnt <= ackCnt + int'(memAck === 1'b1);
      if (cmd === CMD_ACT) actCnt <= actCnt + 1;
      if (cmd === CMD_PRE) preCnt <= preCnt + 1;
      if (cmd === CMD_PRE) preAll <= sdAddr[A10_BIT];
      if (cmd === CMD_REF && sdCke === 1'b1) refCnt <= refCnt + 1;
      if (cmd === CMD_REF && sdCke === 1'b0) slfCnt <= slfCnt + 1;
      if (cmd === CMD_MRS) mrsCnt <= mrsCnt + 1;
      if (cmd === CMD_MRS) mrsAddr <= sdAddr;
      if (cmd !== CMD_NOP && cmd !== CMD_REF && sinceRef < minGap) minGap <= sinceRef;
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1 && ++n < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) chk("pready", 1, pready);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rdreg(input logic [15:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  // One memory access; counts negative mean the command mix is not judged
  task automatic mem(input logic [1:0] b, input logic [12:0] r, input logic [9:0] c,
    input logic w, input int expPre, input int expAct);
    int n = 0;
    int p0 = preCnt;
    int a0 = actCnt;
    @(posedge clk_sys);
    memReq <= 1'b1;
    memWrite <= w;
    memBank <= b;
    memRow <= r;
    memCol <= c;
    do
      @(posedge clk_sys);
    while (memAck !== 1'b1 && ++n < 3000);
    chk("rwCmd", w ? CMD_WRITE : CMD_READ, cmd);
    chk("rwBank", b, sdBa);
    chk("rwCol", c, sdAddr[COL_W-1:0]);
    chk("rwCke", 1, sdCke);
    memReq <= 1'b0;
    @(posedge clk_sys);
    if (expPre >= 0) chk("preCount", expPre, preCnt - p0);
    if (expAct >= 0) chk("actCount", expAct, actCnt - a0);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_init();
    int n = 0;
    int r0 = refCnt;
    wr(ADDR_CTRL, 32'h0);
    repeat (PWRUP_WAIT) @(posedge clk_sys);
    apb(1'b1, 16'ha022, 32'h5a, 4'h1);
    while (preCnt == 0 && n++ < 50) @(posedge clk_sys);
    chk("pallA10", 1, preAll);
    apb(1'b1, 16'ha022, 32'h0, 4'hf);
    chk("strbErr", 1, er);
    apb(1'b0, 16'ha000, 32'h0, 4'h0);
    chk("regionRead", 1, er);
    wr(ADDR_CONST, 32'h8);
    wr(ADDR_CNT, 32'h0);
    wr(ADDR_CTRL, 32'h31);
    wr(ADDR_TCSR, 32'h1);
    while (refCnt < r0 + 8 && n++ < 3000) @(posedge clk_sys);
    chk("autoRefs", 1, refCnt >= r0 + 8);
    rdreg(ADDR_TCSR);
    chk("matchFlag", 1, rd[TCS_MATCH]);
    chk("lockout", 1, minGap >= 3);
    wr(ADDR_CTRL, 32'h35);
    apb(1'b1, 16'ha022, 32'hff, 4'h1);
    n = 0;
    while (mrsCnt == 0 && n++ < 200) @(posedge clk_sys);
    chk("mrsAddr", 32'h22, mrsAddr);
    wr(ADDR_TCSR, 32'h0);
    wr(ADDR_CONST, 32'h100);
    wr(ADDR_CNT, 32'h5);
    rdreg(ADDR_CNT);
    chk("cntHeld", 32'h5, rd);
    wr(ADDR_TCSR, 32'h1);
    repeat (40) @(posedge clk_sys);
    rdreg(ADDR_CNT);
    chk("cntUp", 1, rd > 32'h5 && rd < 32'h14);
    wr(ADDR_TCSR, 32'h0);
    wr(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_access();
    mem(2'd0, 13'd5, 10'd3, 1'b0, 0, 1);
    mem(2'd0, 13'd5, 10'd7, 1'b1, 0, 0);
    mem(2'd0, 13'd9, 10'd1, 1'b0, 1, 1);
    mem(2'd2, 13'd4, 10'd2, 1'b1, 0, 1);
  endtask
  task automatic t_pdown();
    int n = 0;
    while (sdCke !== 1'b0 && n++ < 50) @(posedge clk_sys);
    chk("clkKept1", 2'b11, memClkOutEn);
    @(posedge clk_sys);
    chk("clkKept2", 2'b11, memClkOutEn);
    repeat (6) @(posedge clk_sys);
    chk("ckeLow", 0, sdCke);
    chk("pairClk", 2'b10, memClkOutEn);
    rdreg(ADDR_STAT);
    chk("statPdown", 32'(ST_PDOWN), rd & 32'h0000_047f);
    mem(2'd2, 13'd4, 10'd5, 1'b0, 0, 0);
  endtask
  task automatic t_self();
    int n = 0;
    int a0;
    int r0;
    wr(ADDR_CNT, 32'h0);
    wr(ADDR_CONST, 32'h10);
    wr(ADDR_CTRL, 32'h233);
    wr(ADDR_TCSR, 32'h1);
    while (slfCnt == 0 && n++ < 300) @(posedge clk_sys);
    a0 = ackCnt;
    fork
      mem(2'd1, 13'd3, 10'd1, 1'b0, -1, -1);
      begin
        repeat (30) @(posedge clk_sys);
        chk("selfCke", 0, sdCke);
        sleepMode <= 1'b1;
        wr(ADDR_CTRL, 32'h231);
        repeat (20) @(posedge clk_sys);
        chk("sleepSelf", 0, sdCke);
        chk("noAccess", a0, ackCnt);
        sleepMode <= 1'b0;
      end
    join
    r0 = refCnt;
    n = 0;
    while (refCnt == r0 && n++ < 300) @(posedge clk_sys);
    chk("autoAgain", 1, refCnt > r0);
  endtask
  // Reset, then the scenarios in order, then the verdict
  initial
  begin
    repeat (2) @(posedge clk_sys);
    chk("rstCmd", CMD_NOP, cmd);
    chk("rstCke", 1, sdCke);
    chk("rstClk", 2'b11, memClkOutEn);
    rst <= 1'b0;
    rdreg(ADDR_CTRL);
    chk("ctrlRst", 0, rd);
    rdreg(16'h0014);
    chk("unmapped", 1, er);
    t_init();
    t_access();
    t_pdown();
    t_self();
    chk("protocol", 0, protoErrs);
    tally_and_finish();
  end
endmodule

// ### verif/sdrc_sdram_model.sv
// Behavioural SDRAM partner: tracks open banks, counts illegal commands.
// Assumes the command pins are sampled on the rising edge of clk_sys.
`timescale 1ns/100ps
module sdrc_sdram_model (
  input wire logic clk_sys,
  input wire logic sdCke,
  input wire logic [3:0] cmd,
  input wire logic [1:0] sdBa,
  input wire logic [12:0] sdAddr,
  output int protoErrs
);
  import sdrc_pkg::*;
  logic [3:0] openBanks = '0;
  logic selfRef = 1'b0;
  int errs = 0;
  assign protoErrs = errs;
  // Bank state and command legality
  always @(posedge clk_sys)
  begin
    if (selfRef)
    begin
      if (sdCke === 1'b1)
        selfRef = 1'b0;
      else if (cmd !== CMD_NOP)
        errs += 1;
    end
    else
      case (cmd)
        CMD_ACT:
        begin
          errs += int'(openBanks[sdBa]);
          openBanks[sdBa] = 1'b1;
        end
        CMD_READ, CMD_WRITE: errs += int'(!openBanks[sdBa] || sdCke !== 1'b1);
        CMD_PRE:
        begin
          if (sdAddr[A10_BIT])
            openBanks = '0;
          else
            openBanks[sdBa] = 1'b0;
        end
        CMD_REF:
        begin
          errs += int'(openBanks != 4'h0);
          selfRef = (sdCke === 1'b0);
        end
        CMD_MRS: errs += int'(openBanks != 4'h0);
        default: ;
      endcase
  end
endmodule
